// ===== core/ext_bus_pkg.sv
// Constants and types for the external bus strobe controller.
// Assumes a single 100 MHz system clock domain.
package ext_bus_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int WAIT_W = 3;
	localparam logic [2:0] WAIT_RESET = 3'h0;
	localparam int SYNC_STAGES = 3;
	typedef enum logic [1:0] {SPACE_PROG, SPACE_DATA, SPACE_IO} space_t;
endpackage

// ===== core/pin_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous pin inputs.
// Assumes the input may change at any time relative to sys_clk.
`timescale 1ns/1ps
module pin_sync #(
	parameter logic RESET_VAL = 1'b1
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// Pin and filtered level
	input wire logic pinIn,
	output logic level
);
	logic s1_q, s2_q, s3_q, level_q;
	logic s1_d, s2_d, s3_d, level_d;

	always_comb begin
		s1_d = pinIn;
		s2_d = s1_q;
		s3_d = s2_q;
		// Change accepted only once the last two stages agree
		level_d = (s2_q == s3_q) ? s2_q : level_q;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			s1_q <= RESET_VAL;
			s2_q <= RESET_VAL;
			s3_q <= RESET_VAL;
			level_q <= RESET_VAL;
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			s3_q <= s3_d;
			level_q <= level_d;
		end
	end

	assign level = level_q;
endmodule

// ===== core/external_bus_strobe_control.sv
// External bus strobe controller: space strobes, direction qualifiers, read/write strobes, ready wait states.
// Assumes the core issues one access request at a time and holds it until accDone.
`timescale 1ns/1ps
module external_bus_strobe_control #(
	parameter int WAIT_W = ext_bus_pkg::WAIT_W
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// Core request
	input wire logic accReq,
	input wire logic accWrite,
	input wire ext_bus_pkg::space_t accSpace,
	input wire logic [WAIT_W-1:0] wait_state_config,
	output logic accDone,
	output logic illegalAddr,
	// Device-level controls
	input wire logic powerDown,
	input wire logic test_output_disable_n,
	input wire logic external_interface_enable,
	input wire logic gpioSelect,
	input wire logic gpioOut,
	input wire logic gpioOe,
	output logic gpioIn,
	// External pins
	input wire logic readyPin,
	input wire logic wrRdPinIn,
	output logic program_space_strobe_n,
	output logic data_space_strobe_n,
	output logic io_space_strobe_n,
	output logic spaceOe,
	output logic readWrite_n,
	output logic readWriteOe,
	output logic wrRdPinOut,
	output logic wrRdPinOe,
	output logic read_strobe_n,
	output logic readStrobeOe,
	output logic write_enable_n,
	output logic writeEnableOe,
	output logic external_access_strobe_n,
	output logic accessStrobeOe,
	output logic dataBusOe
);
	if (WAIT_W < 1 || WAIT_W > 8) begin : g_bad_width
		$error("WAIT_W out of range");
	end

	typedef enum logic [1:0] {IDLE, ACCESS, WAITST, DONE} state_t;
	state_t state_q, state_d;
	logic [WAIT_W-1:0] cnt_q, cnt_d;
	logic write_q, write_d;
	ext_bus_pkg::space_t space_q, space_d;
	logic illegal_q, illegal_d;
	logic readyLvl;
	logic offTest;

	// Ready comes from an asynchronous device, so it is filtered first
	pin_sync #(.RESET_VAL(1'b1)) u_ready_sync (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.pinIn(readyPin),
		.level(readyLvl)
	);
	pin_sync #(.RESET_VAL(1'b1)) u_gpio_sync (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.pinIn(wrRdPinIn),
		.level(gpioIn)
	);

	assign offTest = !test_output_disable_n;

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		write_d = write_q;
		space_d = space_q;
		illegal_d = 1'b0;
		unique case (state_q)
			IDLE: begin
				if (accReq) begin
					if (!external_interface_enable) begin
						illegal_d = 1'b1;
						state_d = DONE;
					end else begin
						write_d = accWrite;
						space_d = accSpace;
						cnt_d = wait_state_config;
						state_d = (wait_state_config == '0) ? DONE : WAITST;
					end
				end
			end
			WAITST: begin
				// Ready lags the pin by the synchroniser, so a late low cannot stretch a short wait count
				if (cnt_q > WAIT_W'(1)) begin
					cnt_d = cnt_q - 1'b1;
				end else if (readyLvl) begin
					state_d = ACCESS;
				end
			end
			ACCESS: state_d = DONE;
			DONE: state_d = IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			state_q <= IDLE;
			cnt_q <= WAIT_W'(ext_bus_pkg::WAIT_RESET);
			write_q <= 1'b0;
			space_q <= ext_bus_pkg::SPACE_PROG;
			illegal_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			write_q <= write_d;
			space_q <= space_d;
			illegal_q <= illegal_d;
		end
	end

	logic active;
	// Strobes are held through the whole access; DONE of an illegal access never drives them
	assign active = (state_q == WAITST || state_q == ACCESS || state_q == DONE) && !illegal_q
		&& external_interface_enable;
	assign accDone = (state_q == DONE);
	assign illegalAddr = illegal_q;

	// Single space decode gives one-hot strobes
	assign program_space_strobe_n = !(active && space_q == ext_bus_pkg::SPACE_PROG);
	assign data_space_strobe_n = !(active && space_q == ext_bus_pkg::SPACE_DATA);
	assign io_space_strobe_n = !(active && space_q == ext_bus_pkg::SPACE_IO);
	assign spaceOe = rst_b && !powerDown && !offTest;
	assign readWrite_n = !(active && write_q);
	assign readWriteOe = !powerDown && !offTest;
	assign wrRdPinOut = gpioSelect ? gpioOut : (active && write_q);
	assign wrRdPinOe = gpioSelect ? gpioOe : readWriteOe;
	assign read_strobe_n = !(active && !write_q);
	assign readStrobeOe = !offTest;
	assign write_enable_n = !(active && write_q);
	assign writeEnableOe = !offTest;
	assign dataBusOe = !write_enable_n && !offTest;
	assign external_access_strobe_n = !active;
	assign accessStrobeOe = !powerDown && !offTest;

	a_one_space: assert property (@(posedge sys_clk) disable iff (!rst_b)
		$countones({program_space_strobe_n, data_space_strobe_n, io_space_strobe_n}) >= 2)
		else $error("more than one space strobe low");
	a_strobe_tracks: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(!program_space_strobe_n || !data_space_strobe_n || !io_space_strobe_n) |-> !external_access_strobe_n)
		else $error("space strobe without access strobe");
	a_rw_dir: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!readWrite_n |-> !write_enable_n && read_strobe_n)
		else $error("write qualifier without write strobe");
	a_data_drive: assert property (@(posedge sys_clk) disable iff (!rst_b)
		$fell(write_enable_n) && test_output_disable_n |-> dataBusOe)
		else $error("data bus not driven at write strobe fall");
	a_off_float: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!test_output_disable_n |-> !writeEnableOe && !readStrobeOe && !spaceOe && !accessStrobeOe)
		else $error("output driven in test-off");
	sequence s_waiting;
		state_q == WAITST && cnt_q <= 1 && !readyLvl;
	endsequence
	a_ready_wait: assert property (@(posedge sys_clk) disable iff (!rst_b)
		s_waiting |=> state_q == WAITST)
		else $error("access ended while ready low");
	a_zero_wait: assert property (@(posedge sys_clk) disable iff (!rst_b)
		state_q == IDLE && accReq && external_interface_enable && wait_state_config == '0 |=> accDone)
		else $error("zero wait access not done next cycle");
	a_illegal: assert property (@(posedge sys_clk) disable iff (!rst_b)
		state_q == IDLE && accReq && !external_interface_enable |=> illegalAddr && external_access_strobe_n)
		else $error("disabled interface access not flagged");
	a_wr_inverse: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!gpioSelect |-> wrRdPinOut == !readWrite_n)
		else $error("write/read qualifier not inverse");

	a_idle_strobes: assert property (@(posedge sys_clk) disable iff (!rst_b)
		state_q == IDLE |-> program_space_strobe_n && data_space_strobe_n && io_space_strobe_n
		&& external_access_strobe_n)
		else $error("strobe low while idle");
	a_read_strobe: assert property (@(posedge sys_clk) disable iff (!rst_b)
		state_q == WAITST && !write_q && external_interface_enable |-> !read_strobe_n && write_enable_n)
		else $error("read strobe missing on read");
	a_write_strobe: assert property (@(posedge sys_clk) disable iff (!rst_b)
		state_q == WAITST && write_q && external_interface_enable |-> !write_enable_n && read_strobe_n)
		else $error("write strobe missing on write");
	// Reset floats only the space strobes; the other strobes keep their drivers
	a_reset_float: assert property (@(posedge sys_clk)
		!rst_b |-> !spaceOe)
		else $error("space strobes driven in reset");
	a_power_float: assert property (@(posedge sys_clk) disable iff (!rst_b)
		powerDown |-> !spaceOe && !readWriteOe && !accessStrobeOe)
		else $error("output driven in power down");
	sequence s_ready_seen;
		state_q == WAITST && cnt_q <= 1 && readyLvl;
	endsequence
	a_ready_go: assert property (@(posedge sys_clk) disable iff (!rst_b)
		s_ready_seen |=> state_q == ACCESS ##1 state_q == DONE)
		else $error("access stalled with ready high");
	a_wait_enter: assert property (@(posedge sys_clk) disable iff (!rst_b)
		state_q == IDLE && accReq && external_interface_enable && wait_state_config != '0 |=> state_q == WAITST)
		else $error("programmed wait states skipped");
	a_strobe_release: assert property (@(posedge sys_clk) disable iff (!rst_b)
		accDone |=> external_access_strobe_n)
		else $error("access strobe held after access");
endmodule

// ===== test/ext_mem_model.sv
// External memory model that holds ready low to stretch an access.
// Assumes the access strobe marks the bus cycle; ready idles high (pull-up).
`timescale 1ns/1ps
module ext_mem_model (
	// Clock and strobe
	input wire logic sys_clk,
	input wire logic strobeN,
	input wire logic [3:0] stall,
	// Ready pin
	output logic readyPin
);
	int cnt = 0;
	always @(posedge sys_clk) begin
		if (strobeN) cnt <= 0;
		else if (cnt < 15) cnt <= cnt + 1;
	end
	// Not prepared until stall cycles of the bus cycle have passed
	assign readyPin = strobeN || (cnt >= stall);
endmodule

// ===== test/testbench.sv
// Self-checking bench for the external bus strobe controller.
// Assumes one access at a time; a watcher checks strobes and results.
`timescale 1ns/1ps
module testbench;
	typedef struct {logic ill; int sp; logic wr; int lo; int hi;} note_t;
	logic sys_clk = 0, rst_b = 0, accReq = 0, accWrite = 0, powerDown = 0;
	logic test_output_disable_n = 1, external_interface_enable = 1, wrRdPinIn;
	logic gpioSelect = 0, gpioOut = 0, gpioOe = 0;
	// Ready low reaches the access sampler this many cycles after the strobe falls
	localparam int SEEN = ext_bus_pkg::SYNC_STAGES + 2;
	ext_bus_pkg::space_t accSpace = ext_bus_pkg::SPACE_PROG;
	logic [2:0] wait_state_config = 3'h0;
	logic [3:0] stall = 4'h0;
	logic accDone, illegalAddr, gpioIn, readyPin, program_space_strobe_n, data_space_strobe_n;
	logic io_space_strobe_n, spaceOe, readWrite_n, readWriteOe, wrRdPinOut, wrRdPinOe, read_strobe_n;
	logic readStrobeOe, write_enable_n, writeEnableOe, external_access_strobe_n, accessStrobeOe, dataBusOe;
	logic [2:0] sp;
	int errors = 0, check_count = 0, lat = 0;
	logic [31:0] rng = 32'h00000032;
	note_t q[$];
	note_t t;
	always #5 sys_clk = ~sys_clk;
	// Shared pin has a pull-up when nobody drives it
	assign wrRdPinIn = wrRdPinOe ? wrRdPinOut : 1'b1;
	assign sp = {io_space_strobe_n, data_space_strobe_n, program_space_strobe_n};
	external_bus_strobe_control u_dut (.sys_clk, .rst_b, .accReq, .accWrite, .accSpace, .wait_state_config,
		.accDone, .illegalAddr, .powerDown, .test_output_disable_n, .external_interface_enable,
		.gpioSelect, .gpioOut, .gpioOe, .gpioIn, .readyPin, .wrRdPinIn,
		.program_space_strobe_n, .data_space_strobe_n, .io_space_strobe_n, .spaceOe, .readWrite_n,
		.readWriteOe, .wrRdPinOut, .wrRdPinOe, .read_strobe_n, .readStrobeOe, .write_enable_n,
		.writeEnableOe, .external_access_strobe_n, .accessStrobeOe, .dataBusOe);
	ext_mem_model u_mem (.sys_clk, .strobeN(external_access_strobe_n), .stall, .readyPin);
	function automatic logic [31:0] xorshift(input logic [31:0] v);
		logic [31:0] r;
		r = v ^ (v << 13);
		r = r ^ (r >> 17);
		r = r ^ (r << 5);
		return r;
	endfunction
	task automatic chk(input logic ok, input string m);
		check_count++;
		if (ok !== 1'b1) begin
			errors++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic acc(input int s, input logic w, input logic [2:0] n, input logic e);
		note_t x;
		int expLat;
		rng = xorshift(rng);
		@(negedge sys_clk);
		// Two cycles at least, or the synchroniser filter swallows the low pulse
		stall = rng[3:0] | 4'h2;
		if (!e || n == 0) expLat = 1;
		else if (n >= SEEN && n <= stall + SEEN - 1) expLat = stall + SEEN + 2;
		else expLat = n + 2;
		x = '{!e, s, w, expLat, expLat};
		accSpace = ext_bus_pkg::space_t'(s);
		accWrite = w;
		wait_state_config = n;
		external_interface_enable = e;
		accReq = 1;
		q.push_back(x);
		for (int i = 0; i < 40 && accDone !== 1'b1; i++) @(negedge sys_clk);
		chk(accDone === 1'b1, "access never answered");
		accReq = 0;
		// Let the ready synchroniser settle so one access cannot stall the next
		repeat (5) @(negedge sys_clk);
	endtask
	// Watcher samples settled values just before each rising edge updates
	always @(posedge sys_clk) if (rst_b && test_output_disable_n && !powerDown) begin
		if (q.size() == 0 && accReq !== 1'b1) begin
			chk(sp === 3'h7 && external_access_strobe_n === 1'b1, "strobe low while idle");
		end else if (q.size() > 0) begin
			t = q[0];
			if (t.ill) chk(external_access_strobe_n === 1'b1 && sp === 3'h7, "strobe on refused access");
			else if (external_access_strobe_n === 1'b0) begin
				chk(sp === ~(3'h1 << t.sp), "space strobe");
				chk(readWrite_n === !t.wr && wrRdPinOut === t.wr, "direction qualifiers");
				chk(read_strobe_n === t.wr && write_enable_n === !t.wr, "read or write strobe");
				chk(dataBusOe === t.wr, "data bus drive");
			end
			if (accDone === 1'b1) begin
				void'(q.pop_front());
				chk(illegalAddr === t.ill, "illegal address flag");
				chk(lat >= t.lo && lat <= t.hi, "access length");
				lat = 0;
			end else if (accReq === 1'b1) lat++;
		end
	end
	initial begin
		repeat (6) @(negedge sys_clk);
		chk(spaceOe === 1'b0, "space strobes driven in reset");
		rst_b = 1;
		for (int s = 0; s < 3; s++) for (int w = 0; w < 2; w++) for (int n = 0; n < 8; n++) acc(s, w[0], n[2:0], 1'b1);
		$display("test accesses ended");
		acc(1, 1'b0, 3'h1, 1'b0);
		acc(2, 1'b1, 3'h0, 1'b0);
		$display("test refused accesses ended");
		@(negedge sys_clk);
		chk(wrRdPinOe === 1'b1 && gpioIn === 1'b0, "shared pin idle level");
		test_output_disable_n = 0;
		repeat (5) @(negedge sys_clk);
		chk(gpioIn === 1'b1, "released shared pin not pulled up");
		chk({spaceOe, readWriteOe, readStrobeOe, writeEnableOe, accessStrobeOe} === 5'h00, "test-off");
		test_output_disable_n = 1;
		powerDown = 1;
		repeat (3) @(negedge sys_clk);
		chk({spaceOe, readWriteOe, accessStrobeOe} === 3'h0, "power down");
		powerDown = 0;
		rng = xorshift(rng);
		gpioSelect = 1;
		gpioOe = 1;
		gpioOut = rng[7];
		repeat (5) @(negedge sys_clk);
		chk(wrRdPinOut === gpioOut && gpioIn === gpioOut, "shared pin as port");
		gpioOe = 0;
		repeat (5) @(negedge sys_clk);
		chk(wrRdPinOe === 1'b0 && gpioIn === 1'b1, "shared port released");
		gpioSelect = 0;
		$display("test shared pin ended");
		repeat (2) @(negedge sys_clk);
		acc(0, 1'b1, 3'h2, 1'b1);
		repeat (2) @(negedge sys_clk);
		$display("test float ended");
		stop_test();
	end
	initial begin
		#100us;
		errors++;
		stop_test();
	end
endmodule
